//--- acl_match_pkg.sv
// Shared types and constants for the IP header access-control matcher
`default_nettype none
package acl_match_pkg;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FT_OTHER = 2'h0,
    FT_IPV4 = 2'h1,
    FT_IPV6 = 2'h2
  } frame_type_t;

  typedef enum logic [2:0] {
    PR_ANY = 3'h0,
    PR_SPECIFIC = 3'h1,
    PR_ICMP = 3'h2,
    PR_UDP = 3'h3,
    PR_TCP = 3'h4
  } proto_sel_t;

  // Zero / non-zero / any style tri-state setting
  typedef enum logic [1:0] {
    TRI_NO = 2'h0,
    TRI_YES = 2'h1,
    TRI_ANY = 2'h2
  } tri_sel_t;

  typedef enum logic [1:0] {
    ADDR_ANY = 2'h0,
    ADDR_HOST = 2'h1,
    ADDR_NET = 2'h2
  } addr_sel_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PROTO_ICMP4 = 8'h01;
  localparam logic [7:0] PROTO_ICMP6 = 8'h3a;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam int V6_CMP_BITS = 32;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;
  localparam logic VERDICT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_v4;
    logic is_v6;
    logic [7:0] proto;
    logic [7:0] ttl;
    logic more_frag;
    logic [12:0] frag_offset;
    logic has_options;
    logic [31:0] src_v4;
    logic [31:0] dst_v4;
    logic [127:0] source_v6_address;
  } hdr_fields_t;

  typedef struct packed {
    frame_type_t frame_type;
    proto_sel_t proto_sel;
    logic [7:0] proto_value;
    tri_sel_t ttl_sel;
    tri_sel_t frag_sel;
    tri_sel_t opt_sel;
    addr_sel_t src_sel;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    addr_sel_t dst_sel;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
    proto_sel_t nh_sel;
    logic [7:0] nh_value;
    logic src_v6_specific;
    logic [31:0] src_v6_addr;
    logic [31:0] source_v6_compare_mask;
    tri_sel_t hop_sel;
  } access_control_entry_t;

  typedef struct packed {
    logic hit;
    logic l4_icmp;
    logic l4_udp;
    logic l4_tcp;
  } verdict_t;

endpackage
`default_nettype wire

//--- masked_addr_cmp.sv
// Masked 32-bit address comparator with any/host/network modes
`default_nettype none
module masked_addr_cmp
  import acl_match_pkg::*;
(
  input wire addr_sel_t mode_in,
  input wire logic [31:0] frame_addr,
  input wire logic [31:0] cfg_addr,
  input wire logic [31:0] cfg_mask,
  output logic match
);
  wire addr_sel_t mode = mode_in;
  wire logic [31:0] eff_mask;
  // Zero mask bits are don't-care; host mode compares every bit
  assign eff_mask = (mode == ADDR_HOST) ? MASK_ALL : cfg_mask;
  assign match = (mode == ADDR_ANY) ||
                 ((frame_addr & eff_mask) == (cfg_addr & eff_mask));
endmodule
`default_nettype wire

//--- ip_header_acl_matcher.sv
// IPv4/IPv6 header matcher against one access-control entry
`default_nettype none
// How it works
// - IPv4 conditions apply only when the entry selects IPv4 frames.
// - Protocol any ignores byte; specific requires equality to set value.
// - ICMP/UDP/TCP protocol choices require that protocol and flag L4 checks.
// - TTL zero rejects TTL above zero; non-zero requires it; any ignores.
// - Fragmented means MF set or offset nonzero; no/yes/any select.
// - Options no rejects options, yes requires them, any ignores.
// - IPv4 source address: any, host exact, or network masked.
// - IPv4 destination address: same three modes with own address, mask.
// - Next header ICMP/UDP/TCP require that protocol and flag L4 checks.
// - IPv6 source any ignores; specific compares under configured mask.
// - IPv6 source compare covers only the low 32 address bits.
// - Zero mask bits are don't-care; compare address and mask ANDed.
// - Hop limit zero rejects above zero; non-zero requires; any ignores.
module ip_header_acl_matcher
  import acl_match_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic frame_valid,
  input wire hdr_fields_t hdr,
  input wire access_control_entry_t access_control_entry,
  output logic result_valid_ff,
  output verdict_t verdict_ff
);

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  function automatic logic tri_ok(tri_sel_t sel, logic cond);
    tri_ok = (sel == TRI_ANY) || ((sel == TRI_YES) == cond);
  endfunction

  // Protocol selector match, reused for IPv4 protocol and next header
  function automatic logic proto_ok(proto_sel_t sel, logic [7:0] val,
                                    logic [7:0] cfg, logic [7:0] icmp);
    unique case (sel)
      PR_ANY: proto_ok = 1'b1;
      PR_SPECIFIC: proto_ok = (val == cfg);
      PR_ICMP: proto_ok = (val == icmp);
      PR_UDP: proto_ok = (val == PROTO_UDP);
      PR_TCP: proto_ok = (val == PROTO_TCP);
      default: proto_ok = 1'b0;
    endcase
  endfunction

  wire access_control_entry_t cfg = access_control_entry;
  wire logic sel_v4;
  wire logic sel_v6;
  assign sel_v4 = (cfg.frame_type == FT_IPV4);
  assign sel_v6 = (cfg.frame_type == FT_IPV6);

  // ----------------------------------------------------------------
  // IPv4 conditions
  // ----------------------------------------------------------------
  wire logic v4_proto_ok;
  wire logic v4_ttl_ok;
  wire logic v4_fragmented;
  wire logic v4_frag_ok;
  wire logic v4_opt_ok;
  wire logic source_address_match;
  wire logic dest_address_match;
  wire logic v4_all_ok;

  assign v4_proto_ok = proto_ok(cfg.proto_sel, hdr.proto, cfg.proto_value,
                                PROTO_ICMP4);
  assign v4_ttl_ok = tri_ok(cfg.ttl_sel, hdr.ttl != 8'h00);
  assign v4_fragmented = hdr.more_frag || (hdr.frag_offset != 13'h0000);
  assign v4_frag_ok = tri_ok(cfg.frag_sel, v4_fragmented);
  assign v4_opt_ok = tri_ok(cfg.opt_sel, hdr.has_options);

  masked_addr_cmp u_src_cmp (
    .mode_in(cfg.src_sel),
    .frame_addr(hdr.src_v4),
    .cfg_addr(cfg.src_addr),
    .cfg_mask(cfg.src_mask),
    .match(source_address_match)
  );

  masked_addr_cmp u_dst_cmp (
    .mode_in(cfg.dst_sel),
    .frame_addr(hdr.dst_v4),
    .cfg_addr(cfg.dst_addr),
    .cfg_mask(cfg.dst_mask),
    .match(dest_address_match)
  );

  // Non-IPv4 frames never hit an IPv4 entry
  assign v4_all_ok = hdr.is_v4 && v4_proto_ok && v4_ttl_ok && v4_frag_ok &&
                     v4_opt_ok && source_address_match &&
                     dest_address_match;

  // ----------------------------------------------------------------
  // IPv6 conditions
  // ----------------------------------------------------------------
  wire logic v6_nh_ok;
  wire logic v6_src_ok;
  wire logic v6_hop_ok;
  wire logic v6_all_ok;
  wire logic [V6_CMP_BITS-1:0] v6_low_src;

  // Upper 96 bits deliberately unused by the compare
  assign v6_low_src = hdr.source_v6_address[V6_CMP_BITS-1:0];
  assign v6_nh_ok = proto_ok(cfg.nh_sel, hdr.proto, cfg.nh_value,
                             PROTO_ICMP6);

  masked_addr_cmp u_v6_cmp (
    .mode_in(cfg.src_v6_specific ? ADDR_NET : ADDR_ANY),
    .frame_addr(v6_low_src),
    .cfg_addr(cfg.src_v6_addr),
    .cfg_mask(cfg.source_v6_compare_mask),
    .match(v6_src_ok)
  );

  assign v6_hop_ok = tri_ok(cfg.hop_sel, hdr.ttl != 8'h00);
  assign v6_all_ok = hdr.is_v6 && v6_nh_ok && v6_src_ok && v6_hop_ok;

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  wire logic nxt_hit;
  wire verdict_t nxt_verdict;
  wire logic v4_l4;
  wire logic v6_l4;
  assign v4_l4 = sel_v4 && nxt_hit;
  assign v6_l4 = sel_v6 && nxt_hit;
  // Other frame types: layer-2 checks live elsewhere, treat as don't-care
  assign nxt_hit = sel_v4 ? v4_all_ok :
                   sel_v6 ? v6_all_ok : 1'b1;
  assign nxt_verdict = '{
    hit: nxt_hit,
    l4_icmp: (v4_l4 && cfg.proto_sel == PR_ICMP) ||
             (v6_l4 && cfg.nh_sel == PR_ICMP),
    l4_udp: (v4_l4 && cfg.proto_sel == PR_UDP) ||
            (v6_l4 && cfg.nh_sel == PR_UDP),
    l4_tcp: (v4_l4 && cfg.proto_sel == PR_TCP) ||
            (v6_l4 && cfg.nh_sel == PR_TCP)
  };

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_valid_ff <= 1'b0;
      verdict_ff <= '0;
    end else begin
      result_valid_ff <= frame_valid;
      verdict_ff <= frame_valid ? nxt_verdict : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence v4_entry_s;
    frame_valid && sel_v4;
  endsequence

  v4_type_gate_a: assert property (
    v4_entry_s and !hdr.is_v4 |=> !verdict_ff.hit)
    else $error("IPv4 entry hit a non-IPv4 frame");
  proto_spec_a: assert property (
    v4_entry_s and cfg.proto_sel == PR_SPECIFIC &&
    hdr.proto != cfg.proto_value |=> !verdict_ff.hit)
    else $error("Protocol mismatch still hit");
  proto_tcp_a: assert property (
    v4_entry_s and cfg.proto_sel == PR_TCP && hdr.proto != PROTO_TCP
    |=> !verdict_ff.hit && !verdict_ff.l4_tcp)
    else $error("TCP selection hit another protocol");
  ttl_zero_a: assert property (
    v4_entry_s and cfg.ttl_sel == TRI_NO && hdr.ttl != 8'h00
    |=> !verdict_ff.hit)
    else $error("TTL zero setting let live frame hit");
  frag_no_a: assert property (
    v4_entry_s and cfg.frag_sel == TRI_NO && hdr.frag_offset != 13'h0000
    |=> !verdict_ff.hit)
    else $error("Fragment no setting let fragment hit");
  frag_mf_a: assert property (
    v4_entry_s and cfg.frag_sel == TRI_NO && hdr.more_frag
    |=> !verdict_ff.hit)
    else $error("Fragment no setting let MF frame hit");
  opt_yes_a: assert property (
    v4_entry_s and cfg.opt_sel == TRI_YES && !hdr.has_options
    |=> !verdict_ff.hit)
    else $error("Options yes setting hit frame without options");
  src_host_a: assert property (
    v4_entry_s and cfg.src_sel == ADDR_HOST && hdr.src_v4 != cfg.src_addr
    |=> !verdict_ff.hit)
    else $error("Source host mismatch still hit");
  dst_net_a: assert property (
    v4_entry_s and cfg.dst_sel == ADDR_NET &&
    ((hdr.dst_v4 ^ cfg.dst_addr) & cfg.dst_mask) != 32'h00000000
    |=> !verdict_ff.hit)
    else $error("Destination network mismatch still hit");
  nh_spec_a: assert property (
    frame_valid && sel_v6 && cfg.nh_sel == PR_SPECIFIC &&
    hdr.proto != cfg.nh_value |=> !verdict_ff.hit)
    else $error("Next header mismatch still hit");
  nh_udp_a: assert property (
    frame_valid && sel_v6 && v6_all_ok && cfg.nh_sel == PR_UDP
    |=> verdict_ff.hit && verdict_ff.l4_udp)
    else $error("IPv6 UDP match not flagged");
  v6_src_mask_a: assert property (
    frame_valid && sel_v6 && cfg.src_v6_specific &&
    ((v6_low_src ^ cfg.src_v6_addr) & cfg.source_v6_compare_mask) != '0
    |=> !verdict_ff.hit)
    else $error("IPv6 source mismatch still hit");
  hop_nz_a: assert property (
    frame_valid && sel_v6 && cfg.hop_sel == TRI_YES && hdr.ttl == 8'h00
    |=> !verdict_ff.hit)
    else $error("Hop non-zero setting hit hop zero frame");
  all_any_a: assert property (
    v4_entry_s and hdr.is_v4 && cfg.proto_sel == PR_ANY &&
    cfg.ttl_sel == TRI_ANY && cfg.frag_sel == TRI_ANY &&
    cfg.opt_sel == TRI_ANY && cfg.src_sel == ADDR_ANY &&
    cfg.dst_sel == ADDR_ANY |=> verdict_ff.hit && result_valid_ff)
    else $error("All-any entry failed to hit");
  // Every frame yields exactly one result, one cycle later
  result_pulse_a: assert property (
    frame_valid |=> result_valid_ff)
    else $error("Result valid missing after frame");
  idle_clear_a: assert property (
    !frame_valid |=> !result_valid_ff && verdict_ff == '0)
    else $error("Result or verdict left standing without frame");

endmodule
`default_nettype wire

//--- hdr_source.sv
// Ingress parser model that presents one parsed header per frame
`default_nettype none
module hdr_source
  import acl_match_pkg::*;
(
  output var logic frame_valid,
  output var hdr_fields_t hdr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_valid = 1'b0;
    hdr = '0;
  end

  // Between frames the fields turn to the inverse of the last header; a second idle call in a row restores it
  task automatic put(input logic v, input hdr_fields_t h);
    frame_valid = v;
    hdr = v ? h : ~hdr;
  endtask
endmodule
`default_nettype wire

//--- test_ip_header_acl_matcher.sv
// Self-checking bench for the IP header access-control matcher
`default_nettype none
module test_ip_header_acl_matcher
  import acl_match_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  access_control_entry_t entry = '0;
  logic frame_valid;
  hdr_fields_t hdr;
  logic result_valid_ff;
  verdict_t verdict_ff;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] pv [6] = '{8'h00, 8'h01, 8'h06, 8'h11, 8'h3a, 8'hff};
  logic [7:0] tv [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  logic [31:0] dv [4] = '{32'h0, 32'h1, 32'h100, 32'h80000000};

  always #10 clk = ~clk;

  hdr_source hdr_source_i (.frame_valid(frame_valid), .hdr(hdr));
  ip_header_acl_matcher ip_header_acl_matcher_i (.clk(clk),
    .arst_n(arst_n), .frame_valid(frame_valid), .hdr(hdr),
    .access_control_entry(entry), .result_valid_ff(result_valid_ff),
    .verdict_ff(verdict_ff));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic tri_ok(tri_sel_t s, logic f);
    return s == TRI_ANY || (s == TRI_YES) == f;
  endfunction

  function automatic logic proto_ok(proto_sel_t s, logic [7:0] v,
    logic [7:0] p, logic [7:0] icmp);
    return s == PR_ANY || (s == PR_SPECIFIC && p == v) ||
      (s == PR_ICMP && p == icmp) || (s == PR_UDP && p == 8'h11) ||
      (s == PR_TCP && p == 8'h06);
  endfunction

  function automatic logic addr_ok(addr_sel_t s, logic [31:0] a,
    logic [31:0] c, logic [31:0] m);
    return s == ADDR_ANY || (s == ADDR_HOST && a == c) ||
      (s == ADDR_NET && ((a ^ c) & m) == 32'h0);
  endfunction

  function automatic verdict_t exp_v(access_control_entry_t e,
    hdr_fields_t h);
    verdict_t v;
    proto_sel_t ps;
    logic frag;
    v = '0;
    ps = PR_ANY;
    frag = h.more_frag | (h.frag_offset != 13'h0);
    v.hit = 1'b1;
    if (e.frame_type == FT_IPV4) begin
      ps = e.proto_sel;
      v.hit = h.is_v4 && proto_ok(ps, e.proto_value, h.proto, 8'h01) &&
        tri_ok(e.ttl_sel, h.ttl != 8'h0) && tri_ok(e.frag_sel, frag) &&
        tri_ok(e.opt_sel, h.has_options) &&
        addr_ok(e.src_sel, h.src_v4, e.src_addr, e.src_mask) &&
        addr_ok(e.dst_sel, h.dst_v4, e.dst_addr, e.dst_mask);
    end else if (e.frame_type == FT_IPV6) begin
      ps = e.nh_sel;
      v.hit = h.is_v6 && proto_ok(ps, e.nh_value, h.proto, 8'h3a) &&
        tri_ok(e.hop_sel, h.ttl != 8'h0) && (!e.src_v6_specific ||
        ((h.source_v6_address[31:0] ^ e.src_v6_addr) &
        e.source_v6_compare_mask) == 32'h0);
    end
    v.l4_icmp = v.hit && ps == PR_ICMP;
    v.l4_udp = v.hit && ps == PR_UDP;
    v.l4_tcp = v.hit && ps == PR_TCP;
    return v;
  endfunction

  function automatic access_control_entry_t base_e(frame_type_t ft);
    access_control_entry_t e;
    e = '0;
    e.frame_type = ft;
    e.ttl_sel = TRI_ANY;
    e.frag_sel = TRI_ANY;
    e.opt_sel = TRI_ANY;
    e.hop_sel = TRI_ANY;
    return e;
  endfunction

  function automatic hdr_fields_t base_h(logic v6);
    hdr_fields_t h;
    h = '0;
    h.is_v4 = !v6;
    h.is_v6 = v6;
    h.proto = 8'h06;
    h.ttl = 8'h40;
    h.src_v4 = 32'h0a000001;
    h.dst_v4 = 32'hc0a80105;
    h.source_v6_address = {32'h20010000, 64'h0, 32'h3};
    return h;
  endfunction

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic cmp_bit(string name, logic e, logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic cmp_verdict(string name, verdict_t e, verdict_t g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, e, g);
    end
  endtask

  // Called at a falling edge; back-to-back calls keep frame_valid high
  task automatic send(access_control_entry_t e, hdr_fields_t h);
    entry = e;
    hdr_source_i.put(1'b1, h);
    @(negedge clk);
    cmp_bit("result_valid", 1'b1, result_valid_ff);
    cmp_verdict("verdict", exp_v(e, h), verdict_ff);
  endtask

  task automatic idle();
    hdr_source_i.put(1'b0, '0);
    @(negedge clk);
    cmp_bit("result_valid_idle", 1'b0, result_valid_ff);
    cmp_verdict("verdict_idle", '0, verdict_ff);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    access_control_entry_t e;
    hdr_fields_t h;
    repeat (6) @(negedge clk);
    cmp_bit("result_valid_rst", 1'b0, result_valid_ff);
    arst_n = 1'b1;
    send(base_e(FT_OTHER), base_h(1'b1));
    send(base_e(FT_IPV4), base_h(1'b0));
    send(base_e(FT_IPV4), base_h(1'b1));
    send(base_e(FT_IPV6), base_h(1'b0));
    // Async reset must drop a result that is already standing
    hdr_source_i.put(1'b0, '0);
    arst_n = 1'b0;
    #1;
    cmp_bit("result_valid_arst", 1'b0, result_valid_ff);
    @(negedge clk);
    arst_n = 1'b1;
    for (int s = 0; s < 5; s++) begin
      for (int k = 0; k < 6; k++) begin
        e = base_e(FT_IPV4);
        e.proto_sel = proto_sel_t'(s);
        e.proto_value = 8'hff;
        h = base_h(1'b0);
        h.proto = pv[k];
        send(e, h);
        e.frame_type = FT_IPV6;
        e.nh_sel = proto_sel_t'(s);
        e.nh_value = 8'hff;
        h = base_h(1'b1);
        h.proto = pv[k];
        send(e, h);
      end
    end
    idle();
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 4; k++) begin
        e = base_e(FT_IPV4);
        e.ttl_sel = tri_sel_t'(s);
        h = base_h(1'b0);
        h.ttl = tv[k];
        send(e, h);
        e.ttl_sel = TRI_ANY;
        e.frag_sel = tri_sel_t'(s);
        h = base_h(1'b0);
        h.more_frag = (k == 1);
        h.frag_offset = (k == 2) ? 13'h1 : ((k == 3) ? 13'h1fff : 13'h0);
        send(e, h);
        e.frag_sel = TRI_ANY;
        e.opt_sel = tri_sel_t'(s);
        h = base_h(1'b0);
        h.has_options = k[0];
        send(e, h);
        e = base_e(FT_IPV6);
        e.hop_sel = tri_sel_t'(s);
        h = base_h(1'b1);
        h.ttl = tv[k];
        send(e, h);
      end
    end
    idle();
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 4; k++) begin
        e = base_e(FT_IPV4);
        e.src_sel = addr_sel_t'(s);
        e.src_addr = 32'h0a000001;
        e.src_mask = 32'hffffff00;
        h = base_h(1'b0);
        h.src_v4 = 32'h0a000001 ^ dv[k];
        send(e, h);
        e.src_sel = ADDR_ANY;
        e.dst_sel = addr_sel_t'(s);
        e.dst_addr = 32'hc0a80105;
        e.dst_mask = 32'hffff0000;
        h.dst_v4 = 32'hc0a80105 ^ dv[k];
        send(e, h);
        e = base_e(FT_IPV6);
        e.src_v6_specific = (s != 0);
        e.src_v6_addr = 32'h3;
        e.source_v6_compare_mask = 32'hfffffffe;
        h = base_h(1'b1);
        h.source_v6_address = {32'h20010000 ^ k, 64'h0, 32'h3 ^ dv[k]};
        send(e, h);
      end
    end
    idle();
    final_report();
  end
endmodule
`default_nettype wire
